/* File: hdl/rlsic_pkg.sv */
// Constants, carriers and helpers for the lane status / link parameter bank
// Assumes a 32-bit AXI4-Lite register port on a single 200 MHz clock
package rlsic_pkg;

    localparam int LANES = 8;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_ALIGN_CAL = 8'h00;
    localparam logic [7:0] OFF_CDR_LOCK = 8'h04;
    localparam logic [7:0] OFF_PARAM_ONE = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [7:0] LANE_ZERO = 8'h00;

    // Per-lane monitor inputs
    typedef struct packed {
        logic [7:0] align_valid;
        logic [7:0] cal_busy;
        logic [7:0] cdr_locked;
    } rlsic_lane_t;

    // First link parameter word, field positions as laid out in the word
    typedef struct packed {
        logic [7:0] conv_m1;
        logic [2:0] rsv_hi;
        logic [4:0] frames_k1;
        logic [7:0] octets_f1;
        logic descr_en;
        logic [1:0] rsv_lo;
        logic [4:0] lanes_l1;
    } rlsic_param_t;

    typedef struct packed {
        logic [7:0] rsv_a;
        logic [7:0] align_valid;
        logic [7:0] rsv_b;
        logic [7:0] cal_busy;
    } rlsic_stat2_t;

    typedef struct packed {
        logic [23:0] rsv;
        logic [7:0] cdr_locked;
    } rlsic_stat3_t;

    // Sticky event word: loss of alignment and loss of data lock
    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0] cdr_lost;
        logic [7:0] align_lost;
    } rlsic_irq_t;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] rlsic_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

/* File: hdl/rlsic_sync.sv */
// Two-flop level synchroniser for a group of status bits
// Assumes each bit is a slow level from another clock domain
`timescale 1ns/1ps
module rlsic_sync
    import rlsic_pkg::*;
#(
    parameter int W = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d_async;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;

    AST_SYNC_TWO_STAGE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 2) |-> q_reg == $past(d_async, 2))
        else $error("Sync output not input delayed two cycles");

endmodule

/* File: hdl/rlsic_axil.sv */
// AXI4-Lite slave front end: handshakes, one write and one read at a time
// Assumes the parent decodes addresses and returns data and error flags
`timescale 1ns/1ps
module rlsic_axil
    import rlsic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic awready_reg;
    logic wready_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // Write fires once address and data are both held
    assign wr_en = aw_got_reg && w_got_reg;
    assign wr_addr = awaddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= WORD_ZERO;
            wstrb_reg <= '0;
        end else begin
            if (s_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_awaddr;
            end
            if (s_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                w_got_reg <= 1'b1;
                wdata_reg <= s_wdata;
                wstrb_reg <= s_wstrb;
            end
            if (wr_en) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_reg && s_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= WORD_ZERO;
        end else if (s_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_err ? RESP_SLVERR : RESP_OKAY;
            rdata_reg <= rd_err ? WORD_ZERO : rd_data;
        end else if (rvalid_reg && s_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign s_awready = awready_reg;
    assign s_wready = wready_reg;
    assign s_bvalid = bvalid_reg;
    assign s_bresp = bresp_reg;
    assign s_arready = arready_reg;
    assign s_rvalid = rvalid_reg;
    assign s_rresp = rresp_reg;
    assign s_rdata = rdata_reg;

endmodule

/* File: hdl/rlsic_top.sv */
// Receive lane debug monitors and first link parameter word, AXI4-Lite
// Assumes lane inputs are slow levels from transceiver clock domains
`timescale 1ns/1ps
module rlsic_top
    import rlsic_pkg::*;
#(
    parameter bit RUNTIME_CFG_EN = 1'b1,
    parameter logic [7:0] INIT_CONV_M1 = 8'h01,
    parameter logic [4:0] INIT_FRAMES_K1 = 5'h1f,
    parameter logic [7:0] INIT_OCTETS_F1 = 8'h01,
    parameter logic INIT_DESCR_EN = 1'b1,
    parameter logic [4:0] INIT_LANES_L1 = 5'h03
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic [2:0] s_arprot,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire rlsic_lane_t lane_status_async,
    output rlsic_param_t link_param,
    output logic irq
);

    localparam rlsic_param_t PARAM_INIT = '{
        conv_m1: INIT_CONV_M1,
        rsv_hi: 3'h0,
        frames_k1: INIT_FRAMES_K1,
        octets_f1: INIT_OCTETS_F1,
        descr_en: INIT_DESCR_EN,
        rsv_lo: 2'h0,
        lanes_l1: INIT_LANES_L1
    };
    localparam logic [31:0] IRQ_USED = 32'h0000_ffff;
    localparam int RD_LAT = 1;

    rlsic_lane_t lane_sync;
    rlsic_lane_t lane_prev_reg;
    rlsic_param_t param_reg;
    rlsic_param_t param_next;
    rlsic_irq_t irq_stat_reg;
    rlsic_irq_t irq_mask_reg;
    rlsic_irq_t irq_set;
    rlsic_stat2_t stat2;
    rlsic_stat3_t stat3;
    logic irq_reg;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [31:0] rd_data;
    logic rd_err;
    logic rd_take;

    // Bring per-lane levels into the register clock
    rlsic_sync #(
        .W($bits(rlsic_lane_t))
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d_async(lane_status_async),
        .q(lane_sync)
    );

    rlsic_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Status word images
    always_comb begin
        stat2 = '0;
        stat2.align_valid = lane_sync.align_valid;
        stat2.cal_busy = lane_sync.cal_busy;
        stat3 = '0;
        stat3.cdr_locked = lane_sync.cdr_locked;
    end

    // Read decode
    always_comb begin
        rd_data = WORD_ZERO;
        rd_err = 1'b0;
        case (s_araddr)
            OFF_ALIGN_CAL: rd_data = stat2;
            OFF_CDR_LOCK: rd_data = stat3;
            OFF_PARAM_ONE: rd_data = param_reg;
            OFF_IRQ_STAT: rd_data = irq_stat_reg;
            OFF_IRQ_MASK: rd_data = irq_mask_reg;
            default: rd_err = 1'b1;
        endcase
    end

    // Write decode: status words accept and ignore writes
    always_comb begin
        case (wr_addr)
            OFF_ALIGN_CAL: wr_err = 1'b0;
            OFF_CDR_LOCK: wr_err = 1'b0;
            OFF_PARAM_ONE: wr_err = 1'b0;
            OFF_IRQ_STAT: wr_err = 1'b0;
            OFF_IRQ_MASK: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    // Next parameter word, reserved fields held at zero
    always_comb begin
        param_next = rlsic_merge(param_reg, wr_data, wr_strb);
        param_next.rsv_hi = 3'h0;
        param_next.rsv_lo = 2'h0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            param_reg <= PARAM_INIT;
        end else if (RUNTIME_CFG_EN && wr_en &&
                     wr_addr == OFF_PARAM_ONE) begin
            param_reg <= param_next;
        end
    end

    // Parameter word feeds the alignment sequence sender
    assign link_param = param_reg;

    // Loss events from synchronised levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane_prev_reg <= '0;
        end else begin
            lane_prev_reg <= lane_sync;
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set.align_lost = lane_prev_reg.align_valid &
                             ~lane_sync.align_valid;
        irq_set.cdr_lost = lane_prev_reg.cdr_locked &
                           ~lane_sync.cdr_locked;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= '0;
        end else if (wr_en && wr_addr == OFF_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg &
                ~(rlsic_merge(WORD_ZERO, wr_data, wr_strb) & IRQ_USED))
                | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= '0;
        end else if (wr_en && wr_addr == OFF_IRQ_MASK) begin
            irq_mask_reg <= rlsic_merge(irq_mask_reg, wr_data, wr_strb)
                            & IRQ_USED;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign irq = irq_reg;

    // Read take for checks
    assign rd_take = s_arvalid && s_arready;

    AST_ALIGN_READ: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_take && s_araddr == OFF_ALIGN_CAL |-> ##RD_LAT
        s_rvalid && s_rdata[23:16] == $past(lane_sync.align_valid))
        else $error("Alignment bits not returned in 23:16");

    AST_CAL_READ: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_take && s_araddr == OFF_ALIGN_CAL |=>
        s_rdata[7:0] == $past(lane_sync.cal_busy))
        else $error("Calibration bits not returned in 7:0");

    AST_CDR_READ: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_take && s_araddr == OFF_CDR_LOCK |=>
        s_rdata[7:0] == $past(lane_sync.cdr_locked))
        else $error("Data lock bits not returned in 7:0");

    AST_RSV_ZERO: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_take && (s_araddr == OFF_ALIGN_CAL ||
                    s_araddr == OFF_CDR_LOCK) |=>
        s_rdata[31:24] == LANE_ZERO && s_rdata[15:8] == LANE_ZERO &&
        ($past(s_araddr) != OFF_CDR_LOCK ||
         s_rdata[23:16] == LANE_ZERO))
        else $error("Reserved status bits not zero");

    AST_CONV_WRITE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == OFF_PARAM_ONE && wr_strb[3] &&
        RUNTIME_CFG_EN |=> link_param.conv_m1 == $past(wr_data[31:24]))
        else $error("Converter field not written");

    AST_PARAM_RSV: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == OFF_PARAM_ONE |=> ##[0:2]
        link_param.rsv_hi == 3'h0 && link_param.rsv_lo == 2'h0)
        else $error("Parameter reserved bits not zero");

    AST_PARAM_INIT: assert property (
        @(posedge aclk)
        $rose(aresetn) |-> link_param == PARAM_INIT)
        else $error("Parameter word not at generated value");

    AST_PARAM_LOCK: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !RUNTIME_CFG_EN && $past(aresetn) |-> $stable(link_param))
        else $error("Parameter word changed while locked");

    AST_OCTET_LANE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == OFF_PARAM_ONE && wr_strb[1] && wr_strb[0] &&
        RUNTIME_CFG_EN |=>
        link_param.octets_f1 == $past(wr_data[15:8]) &&
        link_param.descr_en == $past(wr_data[7]) &&
        link_param.lanes_l1 == $past(wr_data[4:0]))
        else $error("Octet, scrambler or lane field not written");

    AST_IRQ_LEVEL: assert property (
        @(posedge aclk) disable iff (!aresetn)
        |(irq_stat_reg & irq_mask_reg) |=> irq)
        else $error("Interrupt not raised for unmasked event");

    AST_SET_WINS: assert property (
        @(posedge aclk) disable iff (!aresetn)
        |irq_set |=> |irq_stat_reg)
        else $error("Event lost against clear");

    AST_IRQ_QUIET: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !(|(irq_stat_reg & irq_mask_reg)) |=> !irq)
        else $error("Interrupt high with no unmasked event");

    AST_STAT_CLEAR: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == OFF_IRQ_STAT && wr_strb[0] && wr_data[0] &&
        !irq_set.align_lost[0] |=> !irq_stat_reg.align_lost[0])
        else $error("Write one did not clear status bit");

endmodule

/* File: test/rlsic_tb.sv */
// Self-checking bench for the lane status and link parameter bank
// Assumes the bank answers AXI4-Lite with one write and one read at a time
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb
    import rlsic_pkg::*;
;
    logic aclk;
    logic aresetn;
    logic [ADDR_W-1:0] s_awaddr;
    logic [2:0] s_awprot;
    logic s_awvalid;
    logic s_awready;
    logic [31:0] s_wdata;
    logic [3:0] s_wstrb;
    logic s_wvalid;
    logic s_wready;
    logic [1:0] s_bresp;
    logic s_bvalid;
    logic s_bready;
    logic [ADDR_W-1:0] s_araddr;
    logic [2:0] s_arprot;
    logic s_arvalid;
    logic s_arready;
    logic [31:0] s_rdata;
    logic [1:0] s_rresp;
    logic s_rvalid;
    logic s_rready;
    rlsic_lane_t lane_status_async;
    rlsic_param_t link_param;
    rlsic_param_t ro_param;
    logic irq;
    int fails = 0;
    int n_checks = 0;

    rlsic_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awprot(s_awprot), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arprot(s_arprot), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .lane_status_async(lane_status_async),
        .link_param(link_param), .irq(irq)
    );

    // Same bus, run-time change disabled
    rlsic_top #(.RUNTIME_CFG_EN(1'b0)) dut_ro (
        .aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awprot(s_awprot), .s_awvalid(s_awvalid),
        .s_awready(), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready(), .s_bresp(), .s_bvalid(),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arprot(s_arprot),
        .s_arvalid(s_arvalid), .s_arready(), .s_rdata(), .s_rresp(),
        .s_rvalid(), .s_rready(s_rready),
        .lane_status_async(lane_status_async), .link_param(ro_param),
        .irq()
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
        input logic [3:0] strb, output logic [1:0] resp);
        bit a, w, b, done;
        int t;
        done = 0;
        t = 0;
        resp = 2'h3;
        @(posedge aclk);
        s_awaddr <= addr;
        s_wdata <= data;
        s_wstrb <= strb;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!done && t < 200) begin
            @(negedge aclk);
            a = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid && s_bready;
            if (b) resp = s_bresp;
            @(posedge aclk);
            if (a) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
            if (b) begin
                s_bready <= 1'b0;
                done = 1;
            end
            t++;
        end
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
        output logic [1:0] resp);
        bit a, r, done;
        int t;
        done = 0;
        t = 0;
        data = 32'hxxxx_xxxx;
        resp = 2'h3;
        @(posedge aclk);
        s_araddr <= addr;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!done && t < 200) begin
            @(negedge aclk);
            a = s_arvalid && s_arready;
            r = s_rvalid && s_rready;
            if (r) begin
                data = s_rdata;
                resp = s_rresp;
            end
            @(posedge aclk);
            if (a) s_arvalid <= 1'b0;
            if (r) begin
                s_rready <= 1'b0;
                done = 1;
            end
            t++;
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp,
        input logic [1:0] eresp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(addr, d, r);
        `CHK(d, exp)
        `CHK(r, eresp)
    endtask

    task automatic wr_chk(input logic [7:0] addr, input logic [31:0] data,
        input logic [3:0] strb, input logic [1:0] eresp);
        logic [1:0] r;
        axi_write(addr, data, strb, r);
        `CHK(r, eresp)
    endtask

    task automatic wait_neg(input int n);
        repeat (n) @(negedge aclk);
    endtask

    task automatic t_reset();
        wait_neg(1);
        `CHK(link_param, 32'h011f_0183)
        `CHK(irq, 1'b0)
        rd_chk(OFF_ALIGN_CAL, WORD_ZERO, RESP_OKAY);
        rd_chk(OFF_CDR_LOCK, WORD_ZERO, RESP_OKAY);
        rd_chk(OFF_PARAM_ONE, 32'h011f_0183, RESP_OKAY);
        rd_chk(OFF_IRQ_STAT, WORD_ZERO, RESP_OKAY);
    endtask

    task automatic t_status();
        lane_status_async <= {8'ha5, 8'h3c, 8'h81};
        wait_neg(4);
        rd_chk(OFF_ALIGN_CAL, 32'h00a5_003c, RESP_OKAY);
        rd_chk(OFF_CDR_LOCK, 32'h0000_0081, RESP_OKAY);
        @(posedge aclk);
        lane_status_async <= {8'hff, 8'hff, 8'hff};
        wait_neg(4);
        wr_chk(OFF_ALIGN_CAL, 32'h0000_0000, 4'hf, RESP_OKAY);
        wr_chk(OFF_CDR_LOCK, 32'h0000_0000, 4'hf, RESP_OKAY);
        rd_chk(OFF_ALIGN_CAL, 32'h00ff_00ff, RESP_OKAY);
        rd_chk(OFF_CDR_LOCK, 32'h0000_00ff, RESP_OKAY);
    endtask

    task automatic t_param();
        wr_chk(OFF_PARAM_ONE, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd_chk(OFF_PARAM_ONE, 32'hff1f_ff9f, RESP_OKAY);
        wait_neg(1);
        `CHK(link_param, 32'hff1f_ff9f)
        wr_chk(OFF_PARAM_ONE, 32'h0000_0000, 4'b0100, RESP_OKAY);
        rd_chk(OFF_PARAM_ONE, 32'hff00_ff9f, RESP_OKAY);
        wr_chk(OFF_PARAM_ONE, 32'h1234_5678, 4'hf, RESP_OKAY);
        rd_chk(OFF_PARAM_ONE, 32'h1214_5618, RESP_OKAY);
        wait_neg(1);
        `CHK(link_param, 32'h1214_5618)
        `CHK(ro_param, 32'h011f_0183)
    endtask

    task automatic t_irq();
        wr_chk(OFF_IRQ_MASK, 32'h0000_8001, 4'hf, RESP_OKAY);
        rd_chk(OFF_IRQ_MASK, 32'h0000_8001, RESP_OKAY);
        @(posedge aclk);
        lane_status_async <= {8'hfe, 8'hff, 8'h7f};
        wait_neg(8);
        rd_chk(OFF_IRQ_STAT, 32'h0000_8001, RESP_OKAY);
        wait_neg(1);
        `CHK(irq, 1'b1)
        wr_chk(OFF_IRQ_STAT, 32'h0000_0001, 4'hf, RESP_OKAY);
        rd_chk(OFF_IRQ_STAT, 32'h0000_8000, RESP_OKAY);
        wr_chk(OFF_IRQ_MASK, 32'h0000_0001, 4'hf, RESP_OKAY);
        wait_neg(2);
        `CHK(irq, 1'b0)
        wr_chk(OFF_IRQ_MASK, 32'h0000_8000, 4'hf, RESP_OKAY);
        wait_neg(2);
        `CHK(irq, 1'b1)
        wr_chk(OFF_IRQ_STAT, 32'h0000_8000, 4'hf, RESP_OKAY);
        wait_neg(2);
        `CHK(irq, 1'b0)
        rd_chk(OFF_IRQ_STAT, WORD_ZERO, RESP_OKAY);
    endtask

    task automatic t_unmapped();
        rd_chk(8'h20, WORD_ZERO, RESP_SLVERR);
        wr_chk(8'h20, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        rd_chk(8'hfc, WORD_ZERO, RESP_SLVERR);
        rd_chk(OFF_PARAM_ONE, 32'h1214_5618, RESP_OKAY);
    endtask

    initial begin
        aresetn = 1'b0;
        s_awaddr = '0;
        s_awprot = 3'h0;
        s_awvalid = 1'b0;
        s_wdata = 32'h0;
        s_wstrb = 4'h0;
        s_wvalid = 1'b0;
        s_bready = 1'b0;
        s_araddr = '0;
        s_arprot = 3'h0;
        s_arvalid = 1'b0;
        s_rready = 1'b0;
        lane_status_async = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_status();
        t_param();
        t_irq();
        t_unmapped();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        test_done();
    end
endmodule
